// >>> core/arc_pkg.sv
// Constants, register map and types shared by the arc trip and common signal logic.
package arc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned STAMP_TIME_MS = 1;
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000 * STAMP_TIME_MS;
  localparam int unsigned PROC_TIME_MS  = 1;
  localparam int unsigned PROC_CYCLES   = CLK_HZ / 1000 * PROC_TIME_MS;
  // Least lead of the blocking input before the operate delay expires.
  localparam int unsigned BLOCK_LEAD_MS = 5;
  localparam int unsigned BLOCK_LEAD_CYCLES = CLK_HZ / 1000 * BLOCK_LEAD_MS;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned NUM_ZONES  = 4;
  localparam int unsigned NUM_CH     = 4;
  localparam int unsigned NUM_STAGES = 8;
  localparam int unsigned CUR_W      = 16;
  localparam int unsigned SENS_W     = 18;
  localparam int unsigned ARC_FLAGS  = 26;
  localparam int unsigned COM_FLAGS  = 2;
  localparam int unsigned REC_DEPTH  = 12;
  localparam int unsigned REC_W      = 32 + 8 + 4 * CUR_W;

  // ****************************************************************
  // Sensor status word field positions
  // ****************************************************************
  localparam int unsigned SB_PH_BLK  = 0;
  localparam int unsigned SB_PH_STR  = 1;
  localparam int unsigned SB_RES_BLK = 2;
  localparam int unsigned SB_RES_STR = 3;
  localparam int unsigned SB_LIGHT   = 4;
  localparam int unsigned SB_PRESS   = 8;
  localparam int unsigned SB_DI      = 12;
  localparam int unsigned SB_SFAULT  = 13;
  localparam int unsigned SB_IOFAULT = 17;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] A_ARC_COND    = 8'h00;
  localparam logic [7:0] A_SENSOR_STAT = 8'h04;
  localparam logic [7:0] A_ARC_ON_MASK = 8'h08;
  localparam logic [7:0] A_ARC_OFF_MSK = 8'h0c;
  localparam logic [7:0] A_COM_MASK    = 8'h10;
  localparam logic [7:0] A_COM_CTRL    = 8'h14;
  localparam logic [7:0] A_COM_COND    = 8'h18;
  localparam logic [7:0] A_COUNT_CLR   = 8'h1c;
  localparam logic [7:0] A_ARC_COUNT   = 8'h20;
  localparam logic [7:0] A_START_COUNT = 8'h24;
  localparam logic [7:0] A_TRIP_COUNT  = 8'h28;
  localparam logic [7:0] A_TIME_NOW    = 8'h2c;
  localparam logic [7:0] A_REC_SEL     = 8'h30;
  localparam logic [7:0] A_REC_PTR     = 8'h34;
  localparam logic [7:0] A_REC_STAMP   = 8'h38;
  localparam logic [7:0] A_REC_EVENT   = 8'h3c;
  localparam logic [7:0] A_REC_IAB     = 8'h40;
  localparam logic [7:0] A_REC_ICR     = 8'h44;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [ARC_FLAGS-1:0] ARC_MASK_RST = {ARC_FLAGS{1'b1}};
  localparam logic [3:0]           COM_MASK_RST = 4'hf;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ZONE_IDLE    = 3'b001,
    ZONE_TRIP    = 3'b010,
    ZONE_BLOCKED = 3'b100
  } zone_state_t;

  typedef enum logic [2:0] {
    COND_NORMAL = 3'b001,
    COND_START  = 3'b010,
    COND_TRIP   = 3'b100
  } com_cond_t;

  typedef enum logic [1:0] {
    OVR_NORMAL = 2'h0,
    OVR_START  = 2'h1,
    OVR_TRIP   = 2'h2
  } override_t;

endpackage : arc_pkg

// >>> core/arc_trip_common.sv
// Arc fault stage outcome, status, events and records, with common signals.
// ****************************************************************
// Overview of operation
// RL1: Blocking input sampled once at each processing cycle start, held all cycle.
// RL2: Zone pick-up with sampled block inactive asserts that zone's trip output.
// RL3: Zone pick-up with sampled block active asserts blocked, no further action.
// RL4: Blocking source must assert it 5 ms before the operate delay ends.
// RL5: Condition word holds trip and blocked flags for each of four zones.
// RL6: Sensor word holds current, light, pressure, input and fault flags.
// RL7: Each rising status change raises ON, each falling change raises OFF.
// RL8: Per-source masks choose whether ON, OFF or both events are stored.
// RL9: Every stored event carries a time stamp taken when it occurred.
// RL10: Arc stage keeps a cumulative event count that software can reset.
// RL11: Events exist for zones, current elements, channels, input and faults.
// RL12: Only twelve newest operation records are kept, oldest overwritten first.
// RL13: Record holds stamp, event, three phase and residual currents, sensors, group.
// RL14: Common start and trip follow any protection stage start or trip.
// RL15: Extra start and trip inputs also drive the common outputs.
// RL16: Override normal, start or trip works only with global forcing enabled.
// RL17: Common settings are static and ignore the active setting group.
// RL18: Common condition readout shows normal, start or trip.
// RL19: Common block has no blocking input of its own.
// RL20: Common start and trip changes raise ON and OFF events.
// RL21: Common block keeps resettable counts of start and trip events.
// RL22: With start and trip both active the common readout reports trip.
//
// The register addresses and the plain strobed port were chosen for this implementation.
module arc_trip_common #(
  parameter int unsigned MS_CYCLES   = arc_pkg::MS_CYCLES,
  parameter int unsigned PROC_CYCLES = arc_pkg::PROC_CYCLES
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic [arc_pkg::NUM_ZONES-1:0] zone_pickup,
  input  wire logic                        block_in,
  input  wire logic                        ph_blocked,
  input  wire logic                        ph_start,
  input  wire logic                        res_blocked,
  input  wire logic                        res_start,
  input  wire logic [arc_pkg::NUM_CH-1:0]  ch_light,
  input  wire logic [arc_pkg::NUM_CH-1:0]  ch_pressure,
  input  wire logic                        di_signal,
  input  wire logic [arc_pkg::NUM_CH-1:0]  sensor_fault,
  input  wire logic                        io_unit_fault,
  input  wire logic [arc_pkg::CUR_W-1:0]   cur_a,
  input  wire logic [arc_pkg::CUR_W-1:0]   cur_b,
  input  wire logic [arc_pkg::CUR_W-1:0]   cur_c,
  input  wire logic [arc_pkg::CUR_W-1:0]   cur_res,
  input  wire logic [2:0]                  setting_group,
  input  wire logic [arc_pkg::NUM_STAGES-1:0] stage_start,
  input  wire logic [arc_pkg::NUM_STAGES-1:0] stage_trip,
  input  wire logic                        extra_start,
  input  wire logic                        extra_trip,
  input  wire logic [7:0]                  addr,
  input  wire logic [31:0]                 wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic      [31:0]                 rdata,
  output logic      [arc_pkg::NUM_ZONES-1:0] zone_trip,
  output logic      [arc_pkg::NUM_ZONES-1:0] zone_blocked,
  output logic                             common_start,
  output logic                             common_trip,
  output logic      [arc_pkg::ARC_FLAGS-1:0] arc_on_evt,
  output logic      [arc_pkg::ARC_FLAGS-1:0] arc_off_evt,
  output logic      [arc_pkg::COM_FLAGS-1:0] com_on_evt,
  output logic      [arc_pkg::COM_FLAGS-1:0] com_off_evt,
  output logic      [31:0]                 event_stamp
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  // ****************************************************************
  // Time base and processing cycle
  // ****************************************************************
  logic [15:0] ms_cnt_reg;
  logic [15:0] proc_cnt_reg;
  logic        cycle_en_reg;
  logic        eval_reg;
  logic [31:0] time_reg;
  wire         ms_tick  = (ms_cnt_reg == 16'(MS_CYCLES - 1));
  wire         proc_end = (proc_cnt_reg == 16'(PROC_CYCLES - 1));
  wire         time_wr  = wr && hit(addr, arc_pkg::A_TIME_NOW);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ms_cnt_reg   <= '0;
      proc_cnt_reg <= '0;
      cycle_en_reg <= 1'b0;
      eval_reg     <= 1'b0;
      time_reg     <= '0;
    end else begin
      ms_cnt_reg   <= ms_tick ? '0 : ms_cnt_reg + 16'h0001;
      proc_cnt_reg <= proc_end ? '0 : proc_cnt_reg + 16'h0001;
      cycle_en_reg <= proc_end;
      eval_reg     <= cycle_en_reg;
      if (time_wr) begin
        time_reg <= wdata;
      end else if (ms_tick) begin
        time_reg <= time_reg + 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // Blocking sample and zone outcome
  // ****************************************************************
  // Pick-up and block are taken together so a block raised mid-cycle
  // cannot turn an already decided trip into a blocked result.
  logic                          blk_smp_reg;
  logic [arc_pkg::NUM_ZONES-1:0] pick_smp_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      blk_smp_reg  <= 1'b0;
      pick_smp_reg <= '0;
    end else if (cycle_en_reg) begin
      blk_smp_reg  <= block_in; // RL1
      pick_smp_reg <= zone_pickup;
    end
  end

  arc_pkg::zone_state_t zone_state_reg [arc_pkg::NUM_ZONES];
  arc_pkg::zone_state_t zone_state_next[arc_pkg::NUM_ZONES];

  genvar z;
  generate
    for (z = 0; z < arc_pkg::NUM_ZONES; z++) begin : g_zone
      always_comb begin
        zone_state_next[z] = zone_state_reg[z];
        case (zone_state_reg[z])
          arc_pkg::ZONE_IDLE: begin
            if (eval_reg && pick_smp_reg[z]) begin
              zone_state_next[z] = blk_smp_reg ? arc_pkg::ZONE_BLOCKED // RL3
                                               : arc_pkg::ZONE_TRIP; // RL2
            end
          end
          arc_pkg::ZONE_TRIP, arc_pkg::ZONE_BLOCKED: begin
            if (eval_reg && !pick_smp_reg[z]) begin
              zone_state_next[z] = arc_pkg::ZONE_IDLE;
            end
          end
          default: zone_state_next[z] = arc_pkg::ZONE_IDLE;
        endcase
      end

      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          zone_state_reg[z] <= arc_pkg::ZONE_IDLE;
          zone_trip[z]      <= 1'b0;
          zone_blocked[z]   <= 1'b0;
        end else begin
          zone_state_reg[z] <= zone_state_next[z];
          zone_trip[z]    <= (zone_state_next[z] == arc_pkg::ZONE_TRIP); // RL2
          zone_blocked[z] <= (zone_state_next[z] == arc_pkg::ZONE_BLOCKED); // RL3
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Status words
  // ****************************************************************
  logic [7:0]                  arc_cond;
  logic [arc_pkg::SENS_W-1:0]  sensor_stat;

  always_comb begin
    for (int i = 0; i < arc_pkg::NUM_ZONES; i++) begin
      arc_cond[2*i]   = zone_trip[i]; // RL5
      arc_cond[2*i+1] = zone_blocked[i]; // RL5
    end
  end

  assign sensor_stat = {io_unit_fault, sensor_fault, di_signal, ch_pressure,
                        ch_light, res_start, res_blocked, ph_start,
                        ph_blocked}; // RL6

  wire [arc_pkg::ARC_FLAGS-1:0] arc_flags = {sensor_stat, arc_cond}; // RL11

  // ****************************************************************
  // Common signals
  // ****************************************************************
  // Only the fixed control register feeds this logic; setting_group is
  // never read here, so a group change cannot alter it.
  logic [1:0] com_ovr_reg;
  logic       force_en_reg;
  wire        start_any = |stage_start || extra_start; // RL14 RL15
  wire        trip_any  = |stage_trip || extra_trip; // RL14 RL15
  wire        ovr_on    = force_en_reg && (com_ovr_reg != 2'(arc_pkg::OVR_NORMAL)); // RL16
  wire        start_n   = ovr_on ? (com_ovr_reg == 2'(arc_pkg::OVR_START))
                                 : start_any; // RL16 RL17 RL19
  wire        trip_n    = ovr_on ? (com_ovr_reg == 2'(arc_pkg::OVR_TRIP))
                                 : trip_any; // RL16 RL17 RL19
  wire [2:0]  com_cond  = common_trip  ? 3'(arc_pkg::COND_TRIP) : // RL22
                          common_start ? 3'(arc_pkg::COND_START) :
                                         3'(arc_pkg::COND_NORMAL); // RL18

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      common_start <= 1'b0;
      common_trip  <= 1'b0;
    end else begin
      common_start <= start_n;
      common_trip  <= trip_n;
    end
  end

  // ****************************************************************
  // Events
  // ****************************************************************
  logic [arc_pkg::ARC_FLAGS-1:0] arc_on_mask_reg;
  logic [arc_pkg::ARC_FLAGS-1:0] arc_off_mask_reg;
  logic [3:0]                    com_mask_reg;
  logic                          arc_edge;
  logic                          com_edge_unused;

  event_edge #(.W(arc_pkg::ARC_FLAGS)) u_arc_evt ( // RL7 RL8 RL11
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .flags    (arc_flags),
    .on_mask  (arc_on_mask_reg),
    .off_mask (arc_off_mask_reg),
    .on_evt   (arc_on_evt),
    .off_evt  (arc_off_evt),
    .any_edge (arc_edge)
  );

  event_edge #(.W(arc_pkg::COM_FLAGS)) u_com_evt ( // RL20
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .flags    ({common_trip, common_start}),
    .on_mask  ({com_mask_reg[2], com_mask_reg[0]}),
    .off_mask ({com_mask_reg[3], com_mask_reg[1]}),
    .on_evt   (com_on_evt),
    .off_evt  (com_off_evt),
    .any_edge (com_edge_unused)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      event_stamp <= '0;
    end else begin
      event_stamp <= time_reg; // RL9
    end
  end

  // ****************************************************************
  // Event counters
  // ****************************************************************
  logic [31:0] arc_count_reg;
  logic [31:0] start_count_reg;
  logic [31:0] trip_count_reg;
  logic        start_prev_reg;
  logic        trip_prev_reg;
  wire         clr_wr    = wr && hit(addr, arc_pkg::A_COUNT_CLR);
  wire         start_rise = common_start && !start_prev_reg;
  wire         trip_rise  = common_trip && !trip_prev_reg;

  // An event landing on the clear cycle is counted from zero, not lost.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      arc_count_reg   <= '0;
      start_count_reg <= '0;
      trip_count_reg  <= '0;
      start_prev_reg  <= 1'b0;
      trip_prev_reg   <= 1'b0;
    end else begin
      start_prev_reg <= common_start;
      trip_prev_reg  <= common_trip;
      arc_count_reg   <= ((clr_wr && wdata[0]) ? '0 : arc_count_reg)
                         + {31'h0, arc_edge}; // RL10
      start_count_reg <= ((clr_wr && wdata[1]) ? '0 : start_count_reg)
                         + {31'h0, start_rise}; // RL21
      trip_count_reg  <= ((clr_wr && wdata[2]) ? '0 : trip_count_reg)
                         + {31'h0, trip_rise}; // RL21
    end
  end

  // ****************************************************************
  // Operation records
  // ****************************************************************
  logic [arc_pkg::REC_W-1:0] rec_mem [arc_pkg::REC_DEPTH];
  logic [3:0]                rec_ptr_reg;
  logic [3:0]                rec_num_reg;
  logic [3:0]                rec_sel_reg;
  logic [arc_pkg::NUM_ZONES-1:0] trip_prev_z_reg;
  wire  [arc_pkg::NUM_ZONES-1:0] trip_rise_z = zone_trip & ~trip_prev_z_reg;
  wire  [1:0] rec_zone = trip_rise_z[0] ? 2'h0 : trip_rise_z[1] ? 2'h1 :
                         trip_rise_z[2] ? 2'h2 : 2'h3;
  wire  [3:0] rec_sens = ch_light | ch_pressure;
  wire  [7:0] rec_evt  = {setting_group, rec_sens, 1'b0} | {6'h0, rec_zone};
  wire        rec_wrap = (rec_ptr_reg == 4'(arc_pkg::REC_DEPTH - 1));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trip_prev_z_reg <= '0;
      rec_ptr_reg     <= '0;
      rec_num_reg     <= '0;
    end else begin
      trip_prev_z_reg <= zone_trip;
      if (|trip_rise_z) begin
        rec_ptr_reg <= rec_wrap ? '0 : rec_ptr_reg + 4'h1; // RL12
        if (rec_num_reg != 4'(arc_pkg::REC_DEPTH)) begin
          rec_num_reg <= rec_num_reg + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (|trip_rise_z) begin
      rec_mem[rec_ptr_reg] <= {time_reg, rec_evt, cur_a, cur_b, cur_c,
                               cur_res}; // RL13
    end
  end

  wire        sel_ok  = (rec_sel_reg < 4'(arc_pkg::REC_DEPTH));
  wire [arc_pkg::REC_W-1:0] rec_rd = sel_ok ? rec_mem[rec_sel_reg] : '0;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      arc_on_mask_reg  <= arc_pkg::ARC_MASK_RST;
      arc_off_mask_reg <= arc_pkg::ARC_MASK_RST;
      com_mask_reg     <= arc_pkg::COM_MASK_RST;
      com_ovr_reg      <= 2'(arc_pkg::OVR_NORMAL);
      force_en_reg     <= 1'b0;
      rec_sel_reg      <= '0;
    end else if (wr) begin
      if (hit(addr, arc_pkg::A_ARC_ON_MASK)) begin
        arc_on_mask_reg <= wdata[arc_pkg::ARC_FLAGS-1:0]; // RL8
      end
      if (hit(addr, arc_pkg::A_ARC_OFF_MSK)) begin
        arc_off_mask_reg <= wdata[arc_pkg::ARC_FLAGS-1:0]; // RL8
      end
      if (hit(addr, arc_pkg::A_COM_MASK)) begin
        com_mask_reg <= wdata[3:0]; // RL8
      end
      if (hit(addr, arc_pkg::A_COM_CTRL)) begin
        com_ovr_reg  <= wdata[1:0]; // RL16
        force_en_reg <= wdata[2];
      end
      if (hit(addr, arc_pkg::A_REC_SEL)) begin
        rec_sel_reg <= wdata[3:0];
      end
    end
  end

  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = '0;
    case (addr)
      arc_pkg::A_ARC_COND:    rdata_next = {24'h0, arc_cond}; // RL5
      arc_pkg::A_SENSOR_STAT: rdata_next = {14'h0, sensor_stat}; // RL6
      arc_pkg::A_ARC_ON_MASK: rdata_next = {6'h0, arc_on_mask_reg};
      arc_pkg::A_ARC_OFF_MSK: rdata_next = {6'h0, arc_off_mask_reg};
      arc_pkg::A_COM_MASK:    rdata_next = {28'h0, com_mask_reg};
      arc_pkg::A_COM_CTRL:    rdata_next = {29'h0, force_en_reg, com_ovr_reg};
      arc_pkg::A_COM_COND:    rdata_next = {29'h0, com_cond}; // RL18
      arc_pkg::A_ARC_COUNT:   rdata_next = arc_count_reg;
      arc_pkg::A_START_COUNT: rdata_next = start_count_reg;
      arc_pkg::A_TRIP_COUNT:  rdata_next = trip_count_reg;
      arc_pkg::A_TIME_NOW:    rdata_next = time_reg;
      arc_pkg::A_REC_SEL:     rdata_next = {28'h0, rec_sel_reg};
      arc_pkg::A_REC_PTR:     rdata_next = {24'h0, rec_num_reg, rec_ptr_reg};
      arc_pkg::A_REC_STAMP:   rdata_next = rec_rd[103:72];
      arc_pkg::A_REC_EVENT:   rdata_next = {24'h0, rec_rd[71:64]};
      arc_pkg::A_REC_IAB:     rdata_next = rec_rd[63:32];
      arc_pkg::A_REC_ICR:     rdata_next = rec_rd[31:0];
      default:                rdata_next = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? rdata_next : '0;
    end
  end

endmodule : arc_trip_common

// >>> core/event_edge.sv
// Edge detector that turns status flags into masked ON and OFF event pulses.
module event_edge #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] flags,
  input  wire logic [W-1:0] on_mask,
  input  wire logic [W-1:0] off_mask,
  output logic      [W-1:0] on_evt,
  output logic      [W-1:0] off_evt,
  output logic              any_edge
);

  logic [W-1:0] prev_reg;
  wire  [W-1:0] rise = flags & ~prev_reg;
  wire  [W-1:0] fall = ~flags & prev_reg;

  // ****************************************************************
  // Edge capture
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prev_reg <= '0;
      on_evt   <= '0;
      off_evt  <= '0;
      any_edge <= 1'b0;
    end else begin
      prev_reg <= flags;
      on_evt   <= rise & on_mask;
      off_evt  <= fall & off_mask;
      any_edge <= |(rise | fall);
    end
  end

endmodule : event_edge

// >>> test/arc_trip_common_sva.sv
// Checker of the common outputs, zone outcome and event pulses.
module arc_trip_common_sva #(
  parameter int unsigned MS_CYCLES   = 10,
  parameter int unsigned PROC_CYCLES = 8
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  zone_pickup,
  input wire logic [7:0]  stage_start,
  input wire logic [7:0]  stage_trip,
  input wire logic        extra_start,
  input wire logic        extra_trip,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic [3:0]  zone_trip,
  input wire logic [3:0]  zone_blocked,
  input wire logic        common_start,
  input wire logic        common_trip,
  input wire logic [25:0] arc_on_evt,
  input wire logic [1:0]  com_on_evt,
  input wire logic [1:0]  com_off_evt
);
  // Forcing hides the plain OR relation, so those checks stand aside.
  logic frc_reg;
  wire  ctl_wr = wr && addr == arc_pkg::A_COM_CTRL;
  wire  calm   = !frc_reg && !ctl_wr;
  always_ff @(posedge sys_clk)
    if (!rst_n) frc_reg <= 1'h0;
    else if (ctl_wr) frc_reg <= wdata[2];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_trip_rise; $rose(common_trip); endsequence
  sequence s_trip_fall; $fell(common_trip); endsequence
  a_start_or: assert property (calm && (|stage_start || extra_start)
    |=> common_start) else $error("common start missing");
  a_trip_or: assert property (calm && (|stage_trip || extra_trip)
    |=> common_trip) else $error("common trip missing");
  a_trip_quiet: assert property (calm && !(|stage_trip) && !extra_trip
    |=> !common_trip) else $error("common trip without cause");
  a_trip_on_evt: assert property (s_trip_rise |=> com_on_evt[1])
    else $error("trip on event missing");
  a_trip_off_evt: assert property (s_trip_fall |=> com_off_evt[1])
    else $error("trip off event missing");
  a_zone_excl: assert property ((zone_trip & zone_blocked) == 4'h0)
    else $error("zone both tripped and blocked");
  a_zone_cause: assert property ($rose(zone_trip[0])
    |-> $past(zone_pickup[0], 2)) else $error("zone trip without pick-up");
  a_zone_evt: assert property ($rose(zone_trip[0])
    |=> arc_on_evt[0] ##1 !arc_on_evt[0]) else $error("zone event wrong");
endmodule : arc_trip_common_sva
bind arc_trip_common arc_trip_common_sva #(.MS_CYCLES(MS_CYCLES),
  .PROC_CYCLES(PROC_CYCLES)) u_sva (.*);

// >>> test/arc_trip_common_test.sv
// Self-checking bench for the arc trip and common signal block.
module arc_trip_common_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = '0, rst_n = '0, wr = '0, rd = '0, want_block = '0;
  logic ph_start = '0, res_blocked = '0, res_start = '0, ph_blocked = '0;
  logic di_signal = '0, io_unit_fault = '0, extra_start = '0;
  logic extra_trip = '0, block_in, common_start, common_trip;
  logic [3:0] want_pickup = '0, ch_light = '0, ch_pressure = '0;
  logic [3:0] sensor_fault = '0, zone_pickup, zone_trip, zone_blocked;
  logic [7:0] want_start = '0, want_trip = '0, addr = '0;
  logic [7:0] stage_start, stage_trip;
  logic [15:0] cur_a = 16'h1111, cur_b = 16'h2222;
  logic [15:0] cur_c = 16'h3333, cur_res = 16'h4444;
  logic [2:0] setting_group = 3'h5;
  logic [31:0] wdata = '0, rdata, event_stamp;
  logic [25:0] arc_on_evt, arc_off_evt, seen;
  logic [1:0] com_on_evt, com_off_evt;
  int miscompares = 0, checks = 0, i;
  always #20 sys_clk = ~sys_clk;
  far_side_model u_far (.*);
  arc_trip_common #(.MS_CYCLES(10), .PROC_CYCLES(8)) u_dut (.*);
  task automatic report_and_stop;
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    cyc(1);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    cyc(1);
    wr <= 1'h0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    cyc(1);
    addr <= a;
    rd <= 1'h1;
    cyc(1);
    rd <= 1'h0;
    #1 chk(rdata, exp);
  endtask : rd_chk
  // Bounded wait; running out of cycles ends the run as a failure.
  task automatic wait_zone(input logic [3:0] tr, input logic [3:0] bl);
    for (i = 0; i < 60 && {zone_trip, zone_blocked} !== {tr, bl}; i++) begin
      cyc(1);
      #1;
    end
    if (i == 60) begin
      miscompares++;
      report_and_stop();
    end
  endtask : wait_zone
  task automatic t_reset;
    rd_chk(arc_pkg::A_ARC_ON_MASK, 32'h03ffffff);
    rd_chk(arc_pkg::A_COM_COND, 32'h1);
    rd_chk(8'hfc, 32'h0);
  endtask : t_reset
  task automatic t_common;
    cyc(1);
    want_start <= 8'h80;
    cyc(3);
    rd_chk(arc_pkg::A_COM_COND, 32'h2);
    cyc(1);
    want_trip <= 8'h01;
    cyc(3);
    rd_chk(arc_pkg::A_COM_COND, 32'h4);
    cyc(1);
    want_start <= 8'h00;
    want_trip <= 8'h00;
    extra_start <= 1'h1;
    cyc(3);
    extra_trip <= 1'h1;
    cyc(3);
    #1 chk({common_trip, common_start}, 32'h3);
    cyc(1);
    extra_start <= 1'h0;
    extra_trip <= 1'h0;
    cyc(4);
    rd_chk(arc_pkg::A_START_COUNT, 32'h1);
    wr_reg(arc_pkg::A_COUNT_CLR, 32'h2);
    rd_chk(arc_pkg::A_START_COUNT, 32'h0);
    rd_chk(arc_pkg::A_TRIP_COUNT, 32'h2);
  endtask : t_common
  task automatic t_force;
    logic [3:0] ctl [5] = '{4'h2, 4'h6, 4'h5, 4'h4, 4'h0};
    logic [3:0] cnd [5] = '{4'h1, 4'h4, 4'h2, 4'h1, 4'h1};
    foreach (ctl[k]) begin
      wr_reg(arc_pkg::A_COM_CTRL, 32'(ctl[k]));
      cyc(3);
      rd_chk(arc_pkg::A_COM_COND, 32'(cnd[k]));
    end
  endtask : t_force
  task automatic t_zone;
    cyc(1);
    want_pickup <= 4'h1;
    wait_zone(4'h1, 4'h0);
    rd_chk(arc_pkg::A_ARC_COND, 32'h1);
    rd_chk(arc_pkg::A_REC_IAB, {cur_a, cur_b});
    rd_chk(arc_pkg::A_REC_ICR, {cur_c, cur_res});
    rd_chk(arc_pkg::A_REC_EVENT, 32'ha0);
    cyc(1);
    want_pickup <= 4'h0;
    want_block <= 1'h1;
    wait_zone(4'h0, 4'h0);
    cyc(1);
    want_pickup <= 4'h2;
    wait_zone(4'h0, 4'h2);
    rd_chk(arc_pkg::A_ARC_COND, 32'h8);
    rd_chk(arc_pkg::A_ARC_COUNT, 32'h3);
    rd_chk(arc_pkg::A_REC_PTR, 32'h11);
  endtask : t_zone
  task automatic t_sensor;
    wr_reg(arc_pkg::A_ARC_ON_MASK, 32'h03fffeff);
    ph_blocked <= 1'h1;
    di_signal <= 1'h1;
    io_unit_fault <= 1'h1;
    ch_light <= 4'h1;
    ch_pressure <= 4'h8;
    sensor_fault <= 4'h1;
    seen = '0;
    repeat (20) begin
      cyc(1);
      seen |= arc_on_evt;
    end
    chk(32'(seen), 32'h02381000);
    rd_chk(arc_pkg::A_SENSOR_STAT, 32'h00023811);
  endtask : t_sensor
  initial begin
    cyc(5);
    rst_n <= 1'h1;
    t_reset();
    t_common();
    t_force();
    t_zone();
    t_sensor();
    report_and_stop();
  end
endmodule : arc_trip_common_test

// >>> test/far_side_model.sv
// Protection stages and blocking matrix that feed the block.
module far_side_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] want_pickup,
  input  wire logic       want_block,
  input  wire logic [7:0] want_start,
  input  wire logic [7:0] want_trip,
  output logic      [3:0] zone_pickup,
  output logic            block_in,
  output logic      [7:0] stage_start,
  output logic      [7:0] stage_trip
);
  logic [3:0] pick_dly;
  // The pick-up lags one stage so a block always leads it.
  always_ff @(posedge sys_clk) begin
    block_in    <= rst_n & want_block;
    pick_dly    <= rst_n ? want_pickup : 4'h0;
    zone_pickup <= pick_dly;
    stage_start <= rst_n ? want_start : 8'h00;
    stage_trip  <= rst_n ? want_trip : 8'h00;
  end
endmodule : far_side_model
